// File: tss_pkg.sv
package tss_pkg;

	// timing of the link clock made by the master
	localparam int CLK_MHZ          = 100;
	localparam int SCL_MAX_KHZ      = 400;
	localparam int KHZ_PER_MHZ      = 1000;
	localparam int QUARTERS_PER_BIT = 4;
	// least quarter length rounds up so the bit rate never exceeds the maximum
	localparam int QUARTER_CYCLES   = (CLK_MHZ * KHZ_PER_MHZ + QUARTERS_PER_BIT * SCL_MAX_KHZ - 1)
		/ (QUARTERS_PER_BIT * SCL_MAX_KHZ);

	// slave addresses, select pin adds the step
	localparam logic [7:0] ADDR_WRITE_BASE  = 8'hc0;
	localparam logic [7:0] ADDR_READ_BASE   = 8'hc1;
	localparam logic [7:0] ADDR_SELECT_STEP = 8'h02;

	// register map
	localparam logic [7:0] REG_LAST_WRITABLE  = 8'h10;
	localparam logic [7:0] REG_CHIP_STATUS    = 8'h11;
	localparam logic [7:0] REG_AUTOTUNER      = 8'h12;
	localparam int         WRITABLE_COUNT     = 17;
	localparam logic [7:0] REG_RESET_VALUE    = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// chip status fields
	localparam int ST_POWER_LOSS   = 7;
	localparam int ST_AUTOSEL_OK   = 6;
	localparam int ST_AUTOSEL_BUSY = 5;
	localparam int ST_LOCK         = 4;
	localparam int ST_NEG_EXC      = 3;
	localparam int ST_POS_EXC      = 2;
	localparam int ST_OVER_THRESH  = 0;

	// autotuner result fields
	localparam int AT_OSC_LSB     = 6;
	localparam int AT_SUBBAND_LSB = 3;
	localparam int AT_VOLT_LSB    = 0;

	// byte framing
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT      = 4'h8;

	// quarters of one bit slot on the master
	localparam logic [1:0] Q_SAMPLE = 2'h2;
	localparam logic [1:0] Q_LAST   = 2'h3;

	typedef enum {TSS_SL_IDLE, TSS_SL_RX, TSS_SL_ACK, TSS_SL_TX, TSS_SL_MACK} tss_slave_state_type;
	typedef enum {TSS_PH_ADDR, TSS_PH_INDEX, TSS_PH_DATA} tss_rx_phase_type;
	typedef enum {
		TSS_H_IDLE, TSS_H_START, TSS_H_ADDRW, TSS_H_INDEX, TSS_H_RSTART,
		TSS_H_ADDRR, TSS_H_WDATA, TSS_H_RDATA, TSS_H_STOP
	} tss_host_state_type;

	function automatic logic [7:0] slave_address(input logic [7:0] base, input logic sel);
		slave_address = sel ? 8'(base + ADDR_SELECT_STEP) : base;
	endfunction

endpackage

// File: tss_link_if.sv
`timescale 1ns/1ps
interface tss_link_if;
	logic scl;
	logic master_sda_out;
	logic master_sda_oe;
	logic slave_sda_out;
	logic slave_sda_oe;
	logic sda;

	// open drain with pull-up: low while any enabled driver pulls low
	assign sda = ~((master_sda_oe & ~master_sda_out) | (slave_sda_oe & ~slave_sda_out));

	modport master (
		output scl,
		output master_sda_out,
		output master_sda_oe,
		input  sda
	);
	modport slave (
		input  scl,
		input  sda,
		output slave_sda_out,
		output slave_sda_oe
	);
endinterface

// File: tss_slave.sv
`timescale 1ns/1ps
module tss_slave (
	// link clock and reset
	input  wire logic                                    link_clk,
	input  wire logic                                    rst_n,
	// serial link
	tss_link_if.slave                                    link,
	// address select pin
	input  wire logic                                    addr_select,
	// tuner status
	input  wire logic                                    autoselect_success_flag,
	input  wire logic                                    autoselect_active_flag,
	input  wire logic                                    synth_lock_flag,
	input  wire logic                                    offset_negative_excursion,
	input  wire logic                                    offset_positive_excursion,
	input  wire logic                                    signal_over_threshold,
	input  wire logic [1:0]                              chosen_oscillator,
	input  wire logic [2:0]                              chosen_subband,
	input  wire logic [2:0]                              tuning_voltage_code,
	// writable register image
	output logic      [tss_pkg::WRITABLE_COUNT*8-1:0]    reg_image
);

	logic [7:0]                   status_raw;
	logic [7:0]                   tune_raw;
	logic [7:0]                   status_meta_reg;
	logic [7:0]                   status_sync_reg;
	logic [7:0]                   tune_meta_reg;
	logic [7:0]                   tune_sync_reg;
	logic                         scl_meta_reg;
	logic                         scl_sync_reg;
	logic                         scl_prev_reg;
	logic                         sda_meta_reg;
	logic                         sda_sync_reg;
	logic                         sda_prev_reg;
	logic                         sel_meta_reg;
	logic                         sel_sync_reg;
	logic                         start_cond;
	logic                         stop_cond;
	logic                         scl_rise;
	logic                         scl_fall;
	logic                         addr_hit;
	logic                         byte_done;
	logic                         tx_load;
	logic [7:0]                   tx_next_byte;
	tss_pkg::tss_slave_state_type state_reg;
	tss_pkg::tss_rx_phase_type    phase_reg;
	logic [3:0]                   bit_cnt_reg;
	logic [7:0]                   shift_reg;
	logic [7:0]                   tx_shift_reg;
	logic [7:0]                   index_reg;
	logic                         read_mode_reg;
	logic                         mack_reg;
	logic                         drive_low_reg;
	logic                         power_loss_reg;
	logic [7:0]                   regs_mem [0:tss_pkg::WRITABLE_COUNT-1];

	// status bytes are packed before the crossing; each field is a slow level
	always_comb begin
		status_raw = '0;
		status_raw[tss_pkg::ST_AUTOSEL_OK]   = autoselect_success_flag;
		status_raw[tss_pkg::ST_AUTOSEL_BUSY] = autoselect_active_flag;
		status_raw[tss_pkg::ST_LOCK]         = synth_lock_flag;
		status_raw[tss_pkg::ST_NEG_EXC]      = offset_negative_excursion;
		status_raw[tss_pkg::ST_POS_EXC]      = offset_positive_excursion;
		status_raw[tss_pkg::ST_OVER_THRESH]  = signal_over_threshold;
		tune_raw = '0;
		tune_raw[tss_pkg::AT_OSC_LSB +: 2]     = chosen_oscillator;
		tune_raw[tss_pkg::AT_SUBBAND_LSB +: 3] = chosen_subband;
		tune_raw[tss_pkg::AT_VOLT_LSB +: 3]    = tuning_voltage_code;
	end

	// two-flop synchronisers; the prev stage reads only the second flop
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_meta_reg <= '0;
			status_sync_reg <= '0;
			tune_meta_reg   <= '0;
			tune_sync_reg   <= '0;
			scl_meta_reg    <= 1'b1;
			scl_sync_reg    <= 1'b1;
			scl_prev_reg    <= 1'b1;
			sda_meta_reg    <= 1'b1;
			sda_sync_reg    <= 1'b1;
			sda_prev_reg    <= 1'b1;
			sel_meta_reg    <= 1'b0;
			sel_sync_reg    <= 1'b0;
		end else begin
			status_meta_reg <= status_raw;
			status_sync_reg <= status_meta_reg;
			tune_meta_reg   <= tune_raw;
			tune_sync_reg   <= tune_meta_reg;
			scl_meta_reg    <= link.scl;
			scl_sync_reg    <= scl_meta_reg;
			scl_prev_reg    <= scl_sync_reg;
			sda_meta_reg    <= link.sda;
			sda_sync_reg    <= sda_meta_reg;
			sda_prev_reg    <= sda_sync_reg;
			sel_meta_reg    <= addr_select;
			sel_sync_reg    <= sel_meta_reg;
		end
	end

	function automatic logic [7:0] read_byte(input logic [7:0] idx);
		if (idx <= tss_pkg::REG_LAST_WRITABLE)
			read_byte = regs_mem[idx[4:0]];
		else if (idx == tss_pkg::REG_CHIP_STATUS) begin
			read_byte = status_sync_reg;
			read_byte[tss_pkg::ST_POWER_LOSS] = power_loss_reg;
		end else if (idx == tss_pkg::REG_AUTOTUNER)
			read_byte = tune_sync_reg;
		else
			read_byte = tss_pkg::UNMAPPED_READ_VALUE;
	endfunction

	// data moving while the clock is high is a condition, never a bit
	assign start_cond = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
	assign stop_cond  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
	assign scl_rise   = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall   = ~scl_sync_reg & scl_prev_reg;
	assign byte_done  = (state_reg == tss_pkg::TSS_SL_RX) && scl_fall
		&& (bit_cnt_reg == tss_pkg::ACK_SLOT);
	// direction bit is the low bit, so both own addresses are compared whole
	assign addr_hit   = (shift_reg == tss_pkg::slave_address(tss_pkg::ADDR_WRITE_BASE, sel_sync_reg))
		|| (shift_reg == tss_pkg::slave_address(tss_pkg::ADDR_READ_BASE, sel_sync_reg));
	// a process rather than an assign so that register and status updates retrigger it
	always_comb tx_next_byte = read_byte(index_reg);
	assign tx_load    = scl_fall && (((state_reg == tss_pkg::TSS_SL_ACK) && read_mode_reg)
		|| ((state_reg == tss_pkg::TSS_SL_MACK) && mack_reg));

	// byte framing and protocol state
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= tss_pkg::TSS_SL_IDLE;
			phase_reg     <= tss_pkg::TSS_PH_ADDR;
			bit_cnt_reg   <= '0;
			shift_reg     <= '0;
			read_mode_reg <= 1'b0;
			mack_reg      <= 1'b0;
		end else if (start_cond) begin
			state_reg     <= tss_pkg::TSS_SL_RX;
			phase_reg     <= tss_pkg::TSS_PH_ADDR;
			bit_cnt_reg   <= '0;
			read_mode_reg <= 1'b0;
		end else if (stop_cond) begin
			state_reg <= tss_pkg::TSS_SL_IDLE;
		end else begin
			case (state_reg)
				tss_pkg::TSS_SL_RX: begin
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_sync_reg};
						bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
					end else if (byte_done) begin
						bit_cnt_reg <= '0;
						if (phase_reg == tss_pkg::TSS_PH_ADDR) begin
							read_mode_reg <= shift_reg[0];
							state_reg     <= addr_hit ? tss_pkg::TSS_SL_ACK : tss_pkg::TSS_SL_IDLE;
						end else begin
							state_reg <= tss_pkg::TSS_SL_ACK;
						end
					end
				end
				tss_pkg::TSS_SL_ACK: begin
					if (scl_fall) begin
						if (read_mode_reg) begin
							state_reg <= tss_pkg::TSS_SL_TX;
						end else begin
							state_reg <= tss_pkg::TSS_SL_RX;
							phase_reg <= (phase_reg == tss_pkg::TSS_PH_ADDR)
								? tss_pkg::TSS_PH_INDEX : tss_pkg::TSS_PH_DATA;
						end
					end
				end
				tss_pkg::TSS_SL_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == tss_pkg::LAST_DATA_BIT) begin
							bit_cnt_reg <= '0;
							state_reg   <= tss_pkg::TSS_SL_MACK;
						end else begin
							bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
						end
					end
				end
				tss_pkg::TSS_SL_MACK: begin
					if (scl_rise)
						mack_reg <= ~sda_sync_reg;
					else if (scl_fall)
						state_reg <= mack_reg ? tss_pkg::TSS_SL_TX : tss_pkg::TSS_SL_IDLE;
				end
				default: state_reg <= tss_pkg::TSS_SL_IDLE;
			endcase
		end
	end

	// register pointer and writable registers
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			index_reg <= '0;
			for (int i = 0; i < tss_pkg::WRITABLE_COUNT; i++)
				regs_mem[i] <= tss_pkg::REG_RESET_VALUE;
		end else if (byte_done && (phase_reg == tss_pkg::TSS_PH_INDEX)) begin
			index_reg <= shift_reg;
		end else if (byte_done && (phase_reg == tss_pkg::TSS_PH_DATA)) begin
			// read-only and unmapped indices are acknowledged but not stored
			if (index_reg <= tss_pkg::REG_LAST_WRITABLE)
				regs_mem[index_reg[4:0]] <= shift_reg;
			index_reg <= 8'(index_reg + 8'h01);
		end else if (tx_load) begin
			index_reg <= 8'(index_reg + 8'h01);
		end
	end

	// power flag comes up set and only a new reset sets it again
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n)
			power_loss_reg <= 1'b1;
		else if (tx_load && (index_reg == tss_pkg::REG_CHIP_STATUS))
			power_loss_reg <= 1'b0;
	end

	// open-drain data driver: only ever pulls low
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_low_reg <= 1'b0;
			tx_shift_reg  <= '0;
		end else if (start_cond || stop_cond) begin
			drive_low_reg <= 1'b0;
		end else if (byte_done) begin
			drive_low_reg <= (phase_reg != tss_pkg::TSS_PH_ADDR) || addr_hit;
		end else if (tx_load) begin
			tx_shift_reg  <= tx_next_byte;
			drive_low_reg <= ~tx_next_byte[7];
		end else if (scl_fall && (state_reg == tss_pkg::TSS_SL_TX)) begin
			tx_shift_reg  <= {tx_shift_reg[6:0], 1'b0};
			// release for the master's acknowledge after the last bit
			drive_low_reg <= (bit_cnt_reg != tss_pkg::LAST_DATA_BIT) && ~tx_shift_reg[6];
		end else if (scl_fall && (state_reg == tss_pkg::TSS_SL_ACK
			|| state_reg == tss_pkg::TSS_SL_MACK)) begin
			drive_low_reg <= 1'b0;
		end
	end

	assign link.slave_sda_out = 1'b0;
	assign link.slave_sda_oe  = drive_low_reg;

	always_comb begin
		for (int i = 0; i < tss_pkg::WRITABLE_COUNT; i++)
			reg_image[i*8 +: 8] = regs_mem[i];
	end

endmodule

// File: tss_master.sv
`timescale 1ns/1ps
module tss_master (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// serial link
	tss_link_if.master      link,
	// command
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic       cmd_read,
	input  wire logic [7:0] cmd_index,
	input  wire logic [3:0] cmd_len,
	input  wire logic       addr_select,
	// write data stream
	input  wire logic [7:0] wr_data,
	output logic            wr_take,
	// read data stream
	output logic      [7:0] rd_data,
	output logic            rd_valid,
	// completion
	output logic            done,
	output logic            nack_error
);

	localparam int QC_W = $clog2(tss_pkg::QUARTER_CYCLES);
	localparam logic [QC_W-1:0] QC_LAST = QC_W'(tss_pkg::QUARTER_CYCLES - 1);

	tss_pkg::tss_host_state_type state_reg;
	logic [QC_W-1:0] qcnt_reg;
	logic [1:0]      q_reg;
	logic [3:0]      bit_cnt_reg;
	logic [7:0]      shift_reg;
	logic [3:0]      remain_reg;
	logic            read_reg;
	logic            sel_reg;
	logic            rx_bit_reg;
	logic            sda_meta_reg;
	logic            sda_sync_reg;
	logic            scl_reg;
	logic            sda_low_reg;
	logic            tick;
	logic            slot_end;
	logic            ack_end;
	logic            acked;
	logic            more;
	logic            slot_bit;
	logic [1:0]      pins;

	// levels of {scl, pull-low} in each quarter of a start, stop or bit slot
	function automatic logic [1:0] pin_levels(input tss_pkg::tss_host_state_type st,
		input logic [1:0] q, input logic b);
		case (st)
			tss_pkg::TSS_H_IDLE:   pin_levels = 2'b10;
			tss_pkg::TSS_H_START,
			tss_pkg::TSS_H_RSTART: pin_levels = {(q == 2'h1) || (q == 2'h2), q[1]};
			tss_pkg::TSS_H_STOP:   pin_levels = {q != 2'h0, ~q[1]};
			default:               pin_levels = {(q == 2'h1) || (q == 2'h2), ~b};
		endcase
	endfunction

	assign tick     = (state_reg != tss_pkg::TSS_H_IDLE) && (qcnt_reg == QC_LAST);
	assign slot_end = tick && (q_reg == tss_pkg::Q_LAST);
	assign ack_end  = slot_end && (bit_cnt_reg == tss_pkg::ACK_SLOT);
	assign acked    = ~rx_bit_reg;
	assign more     = remain_reg != 4'h1;
	assign cmd_ready = state_reg == tss_pkg::TSS_H_IDLE;
	assign wr_take  = ack_end && acked && more && (((state_reg == tss_pkg::TSS_H_INDEX) && !read_reg)
		|| (state_reg == tss_pkg::TSS_H_WDATA)) || (ack_end && acked
		&& (state_reg == tss_pkg::TSS_H_INDEX) && !read_reg);

	// bit to put on the line: sending bytes drive msb first, receiving ones release,
	// and the read acknowledge is low only while more bytes are wanted
	always_comb begin
		if (bit_cnt_reg == tss_pkg::ACK_SLOT)
			slot_bit = (state_reg == tss_pkg::TSS_H_RDATA) ? ~more : 1'b1;
		else
			slot_bit = (state_reg == tss_pkg::TSS_H_RDATA) ? 1'b1 : shift_reg[7];
	end
	assign pins = pin_levels(state_reg, q_reg, slot_bit);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_reg      <= 1'b1;
			sda_low_reg  <= 1'b0;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			qcnt_reg     <= '0;
			q_reg        <= '0;
			rx_bit_reg   <= 1'b1;
		end else begin
			scl_reg      <= pins[1];
			sda_low_reg  <= pins[0];
			sda_meta_reg <= link.sda;
			sda_sync_reg <= sda_meta_reg;
			if (state_reg == tss_pkg::TSS_H_IDLE) begin
				qcnt_reg <= '0;
				q_reg    <= '0;
			end else if (tick) begin
				qcnt_reg <= '0;
				q_reg    <= 2'(q_reg + 2'h1);
				if (q_reg == tss_pkg::Q_SAMPLE)
					rx_bit_reg <= sda_sync_reg;
			end else begin
				qcnt_reg <= QC_W'(qcnt_reg + 1'b1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= tss_pkg::TSS_H_IDLE;
			bit_cnt_reg <= '0;
			shift_reg   <= '0;
			remain_reg  <= '0;
			read_reg    <= 1'b0;
			sel_reg     <= 1'b0;
			rd_data     <= '0;
			rd_valid    <= 1'b0;
			done        <= 1'b0;
			nack_error  <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			done     <= 1'b0;
			case (state_reg)
				tss_pkg::TSS_H_IDLE: begin
					if (cmd_valid) begin
						state_reg  <= tss_pkg::TSS_H_START;
						read_reg   <= cmd_read;
						sel_reg    <= addr_select;
						shift_reg  <= cmd_index;
						remain_reg <= (cmd_len == 4'h0) ? 4'h1 : cmd_len;
						nack_error <= 1'b0;
					end
				end
				tss_pkg::TSS_H_START,
				tss_pkg::TSS_H_RSTART: begin
					if (slot_end) begin
						bit_cnt_reg <= '0;
						if (state_reg == tss_pkg::TSS_H_START) begin
							state_reg <= tss_pkg::TSS_H_ADDRW;
							rd_data   <= shift_reg;
							shift_reg <= tss_pkg::slave_address(tss_pkg::ADDR_WRITE_BASE, sel_reg);
						end else begin
							state_reg <= tss_pkg::TSS_H_ADDRR;
							shift_reg <= tss_pkg::slave_address(tss_pkg::ADDR_READ_BASE, sel_reg);
						end
					end
				end
				tss_pkg::TSS_H_STOP: begin
					if (slot_end) begin
						state_reg <= tss_pkg::TSS_H_IDLE;
						done      <= 1'b1;
					end
				end
				default: begin
					if (slot_end && !ack_end) begin
						bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
						shift_reg   <= {shift_reg[6:0], rx_bit_reg};
					end else if (ack_end) begin
						bit_cnt_reg <= '0;
						if (state_reg == tss_pkg::TSS_H_RDATA) begin
							rd_data    <= shift_reg;
							rd_valid   <= 1'b1;
							remain_reg <= 4'(remain_reg - 4'h1);
							state_reg  <= more ? tss_pkg::TSS_H_RDATA : tss_pkg::TSS_H_STOP;
						end else if (!acked) begin
							// no retry here: the user sees the error and tries again later
							nack_error <= 1'b1;
							state_reg  <= tss_pkg::TSS_H_STOP;
						end else if (state_reg == tss_pkg::TSS_H_ADDRW) begin
							state_reg <= tss_pkg::TSS_H_INDEX;
							shift_reg <= rd_data;
						end else if (state_reg == tss_pkg::TSS_H_ADDRR) begin
							state_reg <= tss_pkg::TSS_H_RDATA;
						end else if (state_reg == tss_pkg::TSS_H_INDEX) begin
							state_reg <= read_reg ? tss_pkg::TSS_H_RSTART : tss_pkg::TSS_H_WDATA;
							shift_reg <= wr_data;
						end else if (more) begin
							remain_reg <= 4'(remain_reg - 4'h1);
							shift_reg  <= wr_data;
						end else begin
							state_reg <= tss_pkg::TSS_H_STOP;
						end
					end
				end
			endcase
		end
	end

	assign link.scl            = scl_reg;
	assign link.master_sda_out = 1'b0;
	assign link.master_sda_oe  = sda_low_reg;

endmodule

// File: tss_link_props.sv
`timescale 1ns/1ps
module tss_link_props (
	// clock and reset
	input wire logic	clk,
	input wire logic	rst_n,
	// link signals
	input wire logic	scl,
	input wire logic	sda,
	input wire logic	master_sda_out,
	input wire logic	master_sda_oe,
	input wire logic	slave_sda_out,
	input wire logic	slave_sda_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic		scl_reg;
	logic [8:0]	per_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_reg <= 1'b1;
		end else begin
			scl_reg <= scl;
		end
	end

	// clocks since the last scl rise; saturates so idle gaps never wrap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			per_reg <= 9'h1ff;
		end else if (scl && !scl_reg) begin
			per_reg <= 9'h000;
		end else if (per_reg != 9'h1ff) begin
			per_reg <= per_reg + 9'h001;
		end
	end

	open_drain_a: assert property (
		!master_sda_out && !slave_sda_out) else $error("data driven high");
	bus_release_a: assert property (
		!master_sda_oe && !slave_sda_oe |-> sda) else $error("released line not high");
	// 400 kHz at 100 MHz leaves at least 250 clocks per bit
	scl_rate_a: assert property (
		scl && !scl_reg |-> per_reg >= 9'h0f9) else $error("serial clock too fast");
	scl_high_a: assert property (
		$rose(scl) |-> scl [*8]) else $error("clock high too short");
	scl_low_a: assert property (
		$fell(scl) |-> !scl [*8]) else $error("clock low too short");
	slave_stable_a: assert property (
		scl && $past(scl) |-> $stable(slave_sda_oe)) else $error("slave moved data in high");
	ack_drive_a: assert property (
		$rose(slave_sda_oe) |-> !scl ##1 !scl) else $error("slave pull not in low phase");
	master_start_a: assert property (
		scl && $past(scl) && $fell(sda) |-> $rose(master_sda_oe))
		else $error("start not made by master");
	master_stop_a: assert property (
		scl && $past(scl) && $rose(sda) |-> $fell(master_sda_oe))
		else $error("stop not made by master");
	cond_release_a: assert property (
		scl && $past(scl) && $changed(sda) |-> !slave_sda_oe)
		else $error("slave pulling at start or stop");
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	logic		clk = 1'b0;
	logic		link_clk = 1'b0;
	logic		rst_n = 1'b0;
	logic		link_rst_n = 1'b0;
	logic		cmd_valid = 1'b0;
	logic		cmd_read = 1'b0;
	logic [7:0]	cmd_index = 8'h00;
	logic [3:0]	cmd_len = 4'h1;
	logic		m_sel = 1'b0;
	logic		s_sel = 1'b0;
	logic [7:0]	wr_data = 8'h00;
	logic [5:0]	flags = 6'h2a;
	logic [1:0]	osc = 2'h2;
	logic [2:0]	sub = 3'h5;
	logic [2:0]	volt = 3'h3;
	logic		cmd_ready, wr_take, rd_valid, done, nack_error;
	logic [7:0]	rd_data;
	logic [135:0]	reg_image;
	logic [7:0]	wq [4];
	logic [7:0]	rq [8];
	int		nrd, n_fail, checked, cycles;

	always #5 clk = ~clk;
	initial begin
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	tss_link_if link ();
	tss_master u_tss_master (.clk(clk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_index(cmd_index),
		.cmd_len(cmd_len), .addr_select(m_sel), .wr_data(wr_data), .wr_take(wr_take),
		.rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack_error(nack_error));
	tss_slave u_tss_slave (.link_clk(link_clk), .rst_n(link_rst_n), .link(link),
		.addr_select(s_sel), .autoselect_success_flag(flags[5]),
		.autoselect_active_flag(flags[4]), .synth_lock_flag(flags[3]),
		.offset_negative_excursion(flags[2]), .offset_positive_excursion(flags[1]),
		.signal_over_threshold(flags[0]), .chosen_oscillator(osc), .chosen_subband(sub),
		.tuning_voltage_code(volt), .reg_image(reg_image));
	tss_link_props u_tss_link_props (.clk(clk), .rst_n(rst_n), .scl(link.scl),
		.sda(link.sda), .master_sda_out(link.master_sda_out),
		.master_sda_oe(link.master_sda_oe), .slave_sda_out(link.slave_sda_out),
		.slave_sda_oe(link.slave_sda_oe));

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// four read commands and one write, from about 2.8k to 19k clocks each, about 55k in all
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [7:0] stat(logic pwr);
		stat = {pwr, flags[5:1], 1'b0, flags[0]};
	endfunction

	task automatic xfer(logic rd, logic [7:0] idx, logic [3:0] len, logic sel);
		int k;
		k = 0;
		nrd = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1) @(negedge clk);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_index = idx;
		cmd_len = len;
		m_sel = sel;
		do begin
			@(negedge clk);
			cmd_valid = 1'b0;
			// data stays up for the edge that takes it, then steps on
			wr_data = wq[k];
			if (wr_take === 1'b1) k++;
			if (rd_valid === 1'b1) begin
				rq[nrd] = rd_data;
				nrd++;
			end
		end while (done !== 1'b1);
	endtask

	task automatic t_write;
		wq = '{8'ha5, 8'h3c, 8'h5a, 8'h00};
		xfer(1'b0, 8'h0f, 4'h3, 1'b0);
		chk("write nack", 8'h00, {7'h00, nack_error});
		chk("reg 0f", 8'ha5, reg_image[120 +: 8]);
		chk("reg 10", 8'h3c, reg_image[128 +: 8]);
	endtask

	task automatic t_read_all;
		xfer(1'b1, 8'h0e, 4'h5, 1'b0);
		chk("read count", 8'h05, nrd[7:0]);
		chk("reg 0e", 8'h00, rq[0]);
		chk("reg 0f", 8'ha5, rq[1]);
		chk("reg 10", 8'h3c, rq[2]);
		chk("status", stat(1'b1), rq[3] & 8'hfd);
		chk("tuner", {osc, sub, volt}, rq[4]);
	endtask

	task automatic t_status_clear;
		flags = 6'h15;
		osc = 2'h1;
		sub = 3'h2;
		volt = 3'h4;
		repeat (20) @(negedge clk);
		xfer(1'b1, 8'h11, 4'h2, 1'b0);
		chk("status", stat(1'b0), rq[0] & 8'hfd);
		chk("tuner", {osc, sub, volt}, rq[1]);
	endtask

	task automatic t_addr_sel;
		s_sel = 1'b1;
		repeat (20) @(negedge clk);
		xfer(1'b1, 8'h0f, 4'h1, 1'b0);
		chk("wrong addr nack", 8'h01, {7'h00, nack_error});
		chk("wrong addr count", 8'h00, nrd[7:0]);
		xfer(1'b1, 8'h0f, 4'h1, 1'b1);
		chk("alt addr nack", 8'h00, {7'h00, nack_error});
		chk("alt addr data", 8'ha5, rq[0]);
	endtask

	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge link_clk);
		link_rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_write();
		t_read_all();
		t_status_clear();
		t_addr_sel();
		complete_run();
	end
endmodule
